/* verilog/ppc_regs.vh */
// register map, field layout, reset values and timing of the port config block
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

// register indices and their byte addresses (address = 4 * index)
`define PPC_IDX_MODE        8'hf0
`define PPC_IDX_PINS        8'hf1
`define PPC_IDX_STAT        8'hf2
`define PPC_ADDR_MODE       12'h3c0
`define PPC_ADDR_PINS       12'h3c4
`define PPC_ADDR_STAT       12'h3c8
`define PPC_ADDR_W          12

// reset values
`define PPC_MODE_RST        8'h3c
`define PPC_PINS_RST        8'h00

// mode register fields
`define PPC_MODE_LSB        0
`define PPC_MODE_MSB        2
`define PPC_THR_LSB         3
`define PPC_THR_MSB         6
`define PPC_ITYPE_BIT       7

// pin sharing register fields
`define PPC_MUX_LSB         0
`define PPC_MUX_MSB         1

// port mode codes
`define PPC_PM_SPP          3'h0
`define PPC_PM_EPP19        3'h1
`define PPC_PM_ECP          3'h2
`define PPC_PM_ECP_EPP19    3'h3
`define PPC_PM_PRINTER      3'h4
`define PPC_PM_EPP17        3'h5
`define PPC_PM_RSVD         3'h6
`define PPC_PM_ECP_EPP17    3'h7

// floppy multiplex codes
`define PPC_MX_NORMAL       2'h0
`define PPC_MX_DRIVE1       2'h1
`define PPC_MX_BOTH         2'h2
`define PPC_MX_RSVD         2'h3

// extended-port sub-mode codes reported by the fifo logic
`define PPC_SUB_SPP         3'h0
`define PPC_SUB_PS2         3'h1
`define PPC_SUB_FIFO        3'h2
`define PPC_SUB_ECP         3'h3
`define PPC_SUB_EPP         3'h4
`define PPC_SUB_TEST        3'h6

// timing
`define PPC_CLK_MHZ         25
`define PPC_IRQ_PULSE_NS    160
`define PPC_IRQ_PULSE_CYC   ((`PPC_IRQ_PULSE_NS * `PPC_CLK_MHZ + 999) / 1000)

`endif

/* verilog/ppc_sync2.v */
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none

module ppc_sync2 #(
    parameter RST_VAL = 1'b1
) (
    // clock and reset
    input  wire hclk,
    input  wire hresetn,
    input  wire hclk_en,
    // level in and out
    input  wire d,
    output reg  q
);

    reg meta_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else if (hclk_en) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

/* verilog/ppc_port_cfg.v */
// parallel port configuration registers with ahb-lite slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"

module ppc_port_cfg #(
    parameter IRQ_PULSE_CYC = `PPC_IRQ_PULSE_CYC
) (
    // clock, reset, enable
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hclk_en,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    // port logic status
    input  wire        ack_n_pin,
    input  wire        port_event,
    input  wire        ecp_level_req,
    input  wire [2:0]  ecp_submode,
    // decoded port mode
    output reg         printer_mode,
    output reg         spp_en,
    output reg         epp_en,
    output reg         epp_rev17,
    output reg         ecp_en,
    output reg  [3:0]  ecp_fifo_threshold,
    // floppy pin sharing
    output reg         second_drive_on_port_pins,
    output reg         both_drives_on_port_pins,
    output reg         fdc_on_port_pins,
    // interrupt pin
    output reg         port_irq_o,
    output reg         port_irq_oe
);

    // ****************************************************************
    // local definitions
    // ****************************************************************
    localparam IRQ_IDLE = 1'b0;
    localparam IRQ_LOW  = 1'b1;
    localparam CNT_W    = 16;
    localparam [CNT_W-1:0] PULSE_LEN = IRQ_PULSE_CYC[CNT_W-1:0];

    // mode code with the reserved value folded onto the default
    function [2:0] ppc_eff_mode;
        input [2:0] code;
        begin
            if (code == `PPC_PM_RSVD)
                ppc_eff_mode = `PPC_PM_PRINTER;
            else
                ppc_eff_mode = code;
        end
    endfunction

    // multiplex code with the reserved value folded onto the default
    function [1:0] ppc_eff_mux;
        input [1:0] code;
        begin
            if (code == `PPC_MX_RSVD)
                ppc_eff_mux = `PPC_MX_NORMAL;
            else
                ppc_eff_mux = code;
        end
    endfunction

    // true for the three extended-port mode codes
    function ppc_is_ecp;
        input [2:0] code;
        begin
            ppc_is_ecp = (code == `PPC_PM_ECP) ||
                         (code == `PPC_PM_ECP_EPP19) ||
                         (code == `PPC_PM_ECP_EPP17);
        end
    endfunction

    // ****************************************************************
    // registers and wires
    // ****************************************************************
    reg  [7:0]       mode_r;
    reg  [7:0]       pins_r;
    reg              wr_pend_r;
    reg  [`PPC_ADDR_W-1:0] wr_addr_r;
    reg              irq_state_r;
    reg              irq_state_nxt;
    reg  [CNT_W-1:0] irq_cnt_r;
    reg  [CNT_W-1:0] irq_cnt_nxt;
    reg              irq_o_nxt;
    reg              irq_oe_nxt;
    reg  [31:0]      rdata_nxt;
    reg  [7:0]       mode_view;
    reg  [7:0]       pins_view;

    wire             ack_n_s;
    wire             bus_go;
    wire [2:0]       eff_mode;
    wire [1:0]       eff_mux;
    wire             itype;
    wire             itype_valid;
    wire             sub_level;
    wire [`PPC_ADDR_W-1:0] acc_addr;

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    ppc_sync2 #(
        .RST_VAL (1'b1)
    ) u_ack_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hclk_en (hclk_en),
        .d       (ack_n_pin),
        .q       (ack_n_s)
    );

    // ****************************************************************
    // bus address phase
    // ****************************************************************
    assign bus_go   = hsel && hready && htrans[1];
    assign acc_addr = haddr[`PPC_ADDR_W-1:0];

    // register views including a write still in its data phase
    always @* begin
        mode_view = mode_r;
        pins_view = pins_r;
        if (wr_pend_r && wr_addr_r == `PPC_ADDR_MODE)
            mode_view = hwdata[7:0];
        if (wr_pend_r && wr_addr_r == `PPC_ADDR_PINS)
            pins_view = {6'h00, hwdata[`PPC_MUX_MSB:`PPC_MUX_LSB]};
    end

    // read data for the access now in its address phase
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (bus_go && !hwrite && haddr[31:`PPC_ADDR_W] == 20'h00000) begin
            case (acc_addr)
                `PPC_ADDR_MODE: begin
                    rdata_nxt = {24'h000000, mode_view};
                end
                `PPC_ADDR_PINS: begin
                    rdata_nxt = {24'h000000, pins_view};
                end
                `PPC_ADDR_STAT: begin
                    rdata_nxt = {24'h000000, port_irq_oe, port_irq_o,
                                 ack_n_s, irq_state_r, 1'b0, eff_mode};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // bus data phase and register storage
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_addr_r <= {`PPC_ADDR_W{1'b0}};
            mode_r    <= `PPC_MODE_RST;
            pins_r    <= `PPC_PINS_RST;
        end else if (hclk_en) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
                hrdata <= rdata_nxt;
            if (wr_pend_r && wr_addr_r == `PPC_ADDR_MODE)
                mode_r <= hwdata[7:0];
            if (wr_pend_r && wr_addr_r == `PPC_ADDR_PINS)
                pins_r <= {6'h00, hwdata[`PPC_MUX_MSB:`PPC_MUX_LSB]};
            if (hready) begin
                wr_pend_r <= bus_go && hwrite &&
                             haddr[31:`PPC_ADDR_W] == 20'h00000;
                wr_addr_r <= acc_addr;
            end
        end
    end

    // ****************************************************************
    // mode decode
    // ****************************************************************
    assign eff_mode = ppc_eff_mode(mode_r[`PPC_MODE_MSB:`PPC_MODE_LSB]);
    assign eff_mux  = ppc_eff_mux(pins_r[`PPC_MUX_MSB:`PPC_MUX_LSB]);
    assign itype    = mode_r[`PPC_ITYPE_BIT];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            printer_mode       <= 1'b1;
            spp_en             <= 1'b0;
            epp_en             <= 1'b0;
            epp_rev17          <= 1'b0;
            ecp_en             <= 1'b0;
            ecp_fifo_threshold <= 4'h7;
        end else if (hclk_en) begin
            ecp_fifo_threshold <= mode_r[`PPC_THR_MSB:`PPC_THR_LSB];
            case (eff_mode)
                `PPC_PM_PRINTER: begin
                    printer_mode <= 1'b1;
                    spp_en       <= 1'b0;
                    epp_en       <= 1'b0;
                    epp_rev17    <= 1'b0;
                    ecp_en       <= 1'b0;
                end
                `PPC_PM_SPP: begin
                    printer_mode <= 1'b0;
                    spp_en       <= 1'b1;
                    epp_en       <= 1'b0;
                    epp_rev17    <= 1'b0;
                    ecp_en       <= 1'b0;
                end
                `PPC_PM_EPP19, `PPC_PM_EPP17: begin
                    printer_mode <= 1'b0;
                    spp_en       <= 1'b1;
                    epp_en       <= 1'b1;
                    epp_rev17    <= (eff_mode == `PPC_PM_EPP17);
                    ecp_en       <= 1'b0;
                end
                `PPC_PM_ECP: begin
                    printer_mode <= 1'b0;
                    spp_en       <= 1'b0;
                    epp_en       <= 1'b0;
                    epp_rev17    <= 1'b0;
                    ecp_en       <= 1'b1;
                end
                `PPC_PM_ECP_EPP19, `PPC_PM_ECP_EPP17: begin
                    printer_mode <= 1'b0;
                    spp_en       <= 1'b0;
                    epp_en       <= 1'b1;
                    epp_rev17    <= (eff_mode == `PPC_PM_ECP_EPP17);
                    ecp_en       <= 1'b1;
                end
                default: begin
                    printer_mode <= 1'b1;
                    spp_en       <= 1'b0;
                    epp_en       <= 1'b0;
                    epp_rev17    <= 1'b0;
                    ecp_en       <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // floppy pin sharing
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_drive_on_port_pins <= 1'b0;
            both_drives_on_port_pins  <= 1'b0;
            fdc_on_port_pins          <= 1'b0;
        end else if (hclk_en) begin
            case (eff_mux)
                `PPC_MX_DRIVE1: begin
                    second_drive_on_port_pins <= 1'b1;
                    both_drives_on_port_pins  <= 1'b0;
                    fdc_on_port_pins          <= 1'b1;
                end
                `PPC_MX_BOTH: begin
                    second_drive_on_port_pins <= 1'b0;
                    both_drives_on_port_pins  <= 1'b1;
                    fdc_on_port_pins          <= 1'b1;
                end
                default: begin
                    second_drive_on_port_pins <= 1'b0;
                    both_drives_on_port_pins  <= 1'b0;
                    fdc_on_port_pins          <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // interrupt pin
    // ****************************************************************
    assign itype_valid = !(eff_mode == `PPC_PM_PRINTER ||
                           eff_mode == `PPC_PM_SPP);
    assign sub_level   = ppc_is_ecp(eff_mode) &&
                         (ecp_submode == `PPC_SUB_FIFO ||
                          ecp_submode == `PPC_SUB_ECP  ||
                          ecp_submode == `PPC_SUB_TEST);

    always @* begin
        irq_state_nxt = irq_state_r;
        irq_cnt_nxt   = irq_cnt_r;
        irq_o_nxt     = 1'b1;
        irq_oe_nxt    = 1'b1;
        if (itype_valid && itype) begin
            irq_oe_nxt = 1'b0;
            case (irq_state_r)
                IRQ_IDLE: begin
                    if (port_event) begin
                        irq_state_nxt = IRQ_LOW;
                        irq_cnt_nxt   = PULSE_LEN - 16'h0001;
                        irq_o_nxt     = 1'b0;
                        irq_oe_nxt    = 1'b1;
                    end
                end
                IRQ_LOW: begin
                    if (irq_cnt_r == 16'h0000) begin
                        irq_state_nxt = IRQ_IDLE;
                    end else begin
                        irq_cnt_nxt = irq_cnt_r - 16'h0001;
                        irq_o_nxt   = 1'b0;
                        irq_oe_nxt  = 1'b1;
                    end
                end
                default: begin
                    irq_state_nxt = IRQ_IDLE;
                end
            endcase
        end else begin
            irq_state_nxt = IRQ_IDLE;
            irq_cnt_nxt   = 16'h0000;
            if (itype_valid && sub_level)
                irq_o_nxt = ecp_level_req;
            else
                irq_o_nxt = ack_n_s;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_state_r <= IRQ_IDLE;
            irq_cnt_r   <= 16'h0000;
            port_irq_o  <= 1'b1;
            port_irq_oe <= 1'b1;
        end else if (hclk_en) begin
            irq_state_r <= irq_state_nxt;
            irq_cnt_r   <= irq_cnt_nxt;
            port_irq_o  <= irq_o_nxt;
            port_irq_oe <= irq_oe_nxt;
        end
    end

endmodule

`default_nettype wire

/* test/ppc_printer_model.sv */
// printer side model: drives the acknowledge pin, resolves the irq pin
`timescale 1ns/1ps
`default_nettype none
module ppc_printer_model (
    // clock
    input  wire logic hclk,
    // interrupt pin from the block
    input  wire logic port_irq_o,
    input  wire logic port_irq_oe,
    // printer pins
    output var  logic ack_n_pin,
    output wire logic irq_pin
);
    // released pin floats: no pull on this line
    assign irq_pin = port_irq_oe ? port_irq_o : 1'bz;
    initial ack_n_pin = 1'b1;
    task automatic set_ack(input logic v);
        @(posedge hclk);
        ack_n_pin <= v;
    endtask
endmodule
`default_nettype wire

/* test/ppc_port_cfg_chk.sv */
// assertions on the ports of the parallel port config block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_port_cfg_chk #(
    parameter IRQ_PULSE_CYC = 4
) (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic        hready,
    input wire logic        hwrite,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    // decoded outputs
    input wire logic        printer_mode,
    input wire logic        spp_en,
    input wire logic        epp_en,
    input wire logic        epp_rev17,
    input wire logic        ecp_en,
    input wire logic [3:0]  ecp_fifo_threshold,
    input wire logic        second_drive_on_port_pins,
    input wire logic        both_drives_on_port_pins,
    input wire logic        port_irq_o,
    input wire logic        port_irq_oe
);
    // ***********************************
    // write tracking and pulse counter
    // ***********************************
    wire        req = hsel & hready & htrans[1] & hwrite & ~|haddr[31:12];
    logic       wm_r;
    logic       wp_r;
    logic [7:0] low_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wm_r <= 1'b0;
            wp_r <= 1'b0;
            low_r <= 8'h00;
        end else begin
            wm_r <= req & (haddr[11:0] == `PPC_ADDR_MODE);
            wp_r <= req & (haddr[11:0] == `PPC_ADDR_PINS);
            low_r <= (port_irq_oe & ~port_irq_o) ? low_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ***********************************
    // assertions
    // ***********************************
    chk_printer_decode: assert property (wm_r && hwdata[2:0] == 3'h4
        |-> ##2 printer_mode && !epp_en && !ecp_en) else $error("printer");
    chk_spp_decode: assert property (wm_r && hwdata[2:0] == 3'h0
        |-> ##2 spp_en && !printer_mode && !epp_en && !ecp_en)
        else $error("spp decode");
    chk_epp_decode: assert property (wm_r && hwdata[1:0] == 2'h1
        |-> ##2 epp_en && spp_en && !ecp_en
        && epp_rev17 == $past(hwdata[2], 2)) else $error("epp decode");
    chk_ecp_decode: assert property (wm_r && hwdata[1]
        && hwdata[2:0] != 3'h6 |-> ##2 ecp_en && !printer_mode
        && epp_en == $past(hwdata[0], 2)
        && (!epp_en || epp_rev17 == $past(hwdata[2], 2)))
        else $error("ecp decode");
    chk_fifo_thresh: assert property (wm_r
        |-> ##2 ecp_fifo_threshold == $past(hwdata[6:3], 2))
        else $error("threshold");
    chk_mux_decode: assert property (wp_r |-> ##2
        second_drive_on_port_pins == ($past(hwdata[1:0], 2) == 2'h1)
        && both_drives_on_port_pins == ($past(hwdata[1:0], 2) == 2'h2))
        else $error("mux decode");
    chk_pulse_len: assert property ($fell(port_irq_oe) && !$past(port_irq_o)
        |-> port_irq_o && low_r == IRQ_PULSE_CYC) else $error("pulse");
    chk_printer_drive: assert property (printer_mode[*3]
        |-> port_irq_oe) else $error("irq released in printer mode");
endmodule
bind ppc_port_cfg ppc_port_cfg_chk #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_chk (
    .hclk, .hresetn, .hsel, .hready, .hwrite, .htrans, .haddr, .hwdata,
    .printer_mode, .spp_en, .epp_en, .epp_rev17, .ecp_en,
    .ecp_fifo_threshold, .second_drive_on_port_pins,
    .both_drives_on_port_pins, .port_irq_o, .port_irq_oe
);
`default_nettype wire

/* test/ppc_port_cfg_test.sv */
// self-checking bench for the parallel port config block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_port_cfg_test;
    localparam PW = 4;
    localparam logic [31:0] AM = {20'h0, `PPC_ADDR_MODE};
    localparam logic [31:0] AP = {20'h0, `PPC_ADDR_PINS};
    localparam logic [31:0] AS = {20'h0, `PPC_ADDR_STAT};
    localparam logic [17:0] SMS = {3'h6, 3'h3, 3'h2, 3'h4, 3'h1, 3'h0};
    logic        hclk, hresetn, hsel, hwrite, port_event, ecp_level_req;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, ecp_submode;
    wire         hreadyout, hresp, prn, spp, epp, r17, ecp, d1, d2, fdc;
    wire         irq_o, irq_oe, ack_n, irq_pin;
    wire  [31:0] hrdata;
    wire  [3:0]  thr;
    int          miscompares, tests_run;
    ppc_port_cfg #(.IRQ_PULSE_CYC(PW)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hclk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ack_n_pin(ack_n),
        .port_event(port_event), .ecp_level_req(ecp_level_req),
        .ecp_submode(ecp_submode), .printer_mode(prn), .spp_en(spp),
        .epp_en(epp), .epp_rev17(r17), .ecp_en(ecp),
        .ecp_fifo_threshold(thr), .second_drive_on_port_pins(d1),
        .both_drives_on_port_pins(d2), .fdc_on_port_pins(fdc),
        .port_irq_o(irq_o), .port_irq_oe(irq_oe));
    ppc_printer_model i_prn (.hclk(hclk), .port_irq_o(irq_o),
        .port_irq_oe(irq_oe), .ack_n_pin(ack_n), .irq_pin(irq_pin));
    // ***********************************
    // shared tasks
    // ***********************************
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        repeat (3) @(negedge hclk);
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    task automatic event_pulse;
        @(posedge hclk);
        port_event <= 1'b1;
        @(posedge hclk);
        port_event <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_reset;
        rd_chk("mode_rst", AM, 32'h3c);
        rd_chk("pins_rst", AP, 32'h0);
        rd_chk("unmapped", 32'h1000, 32'h0);
        rd_chk("stat_rst", AS, 32'he4);
        chk("resp", hresp, 1'b0);
        chk("printer_rst", prn, 1'b1);
        chk("thr_rst", thr, 4'h7);
        chk("mux_rst", {d1, d2, fdc}, 3'h0);
        $display("reset test done");
    endtask
    task automatic t_modes;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {1'b0, 4'(c ^ 5), 3'(c)};
            wr(AM, {24'h0, d});
            chk("printer", prn, 8'h50 >> c & 1);
            chk("epp", epp, 8'haa >> c & 1);
            chk("rev17", r17 & epp, 8'ha0 >> c & 1);
            chk("ecp", ecp, 8'h8c >> c & 1);
            chk("spp", spp, 8'h23 >> c & 1);
            chk("thr", thr, 4'(c ^ 5));
            rd_chk("mode_rb", AM, {24'h0, d});
        end
        $display("mode test done");
    endtask
    task automatic t_mux;
        for (int m = 0; m < 4; m++) begin
            wr(AP, 32'(m));
            chk("drive1", d1, m == 1);
            chk("both", d2, m == 2);
            chk("fdc", fdc, m == 1 || m == 2);
            rd_chk("pins_rb", AP, 32'(m));
        end
        $display("mux test done");
    endtask
    task automatic t_pulse;
        wr(AM, 32'h81);
        repeat (2) begin
            event_pulse;
            for (int i = 1; i <= PW + 2; i++) begin
                @(negedge hclk);
                chk("pulse_oe", irq_oe, i <= PW);
                chk("pulse_o", irq_o, i > PW);
            end
            chk("pin_z", irq_pin, 1'bz);
        end
        $display("pulse test done");
    endtask
    task automatic t_std;
        for (int j = 0; j < 2; j++) begin
            wr(AM, j ? 32'h80 : 32'h84);
            event_pulse;
            repeat (PW + 2) @(negedge hclk);
            chk("std_oe", irq_oe, 1'b1);
            chk("std_o", irq_o, 1'b1);
        end
        wr(AM, 32'h01);
        i_prn.set_ack(1'b0);
        repeat (5) @(negedge hclk);
        chk("epp_ack_lo", {irq_oe, irq_o}, 2'h2);
        i_prn.set_ack(1'b1);
        repeat (5) @(negedge hclk);
        chk("epp_ack_hi", {irq_oe, irq_o}, 2'h3);
        $display("nack test done");
    endtask
    task automatic t_level;
        wr(AM, 32'h02);
        for (int k = 0; k < 6; k++) begin
            @(posedge hclk);
            ecp_submode <= SMS[k*3+:3];
            ecp_level_req <= 1'b1;
            i_prn.set_ack(1'b0);
            repeat (5) @(negedge hclk);
            chk("lvl_a", irq_o, k >= 3);
            @(posedge hclk);
            ecp_level_req <= 1'b0;
            i_prn.set_ack(1'b1);
            repeat (5) @(negedge hclk);
            chk("lvl_b", irq_o, k < 3);
        end
        $display("level test done");
    endtask
    // ***********************************
    // clock, reset, sequence, watchdog
    // ***********************************
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        port_event = 1'b0;
        ecp_level_req = 1'b0;
        ecp_submode = 3'h0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_modes;
        t_mux;
        t_pulse;
        t_std;
        t_level;
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
